//--- core/jack_detect_pkg.sv
// constants shared by the jack detect status logic and its debounce filter
// assumes a single 100 MHz clock and a byte-wide register port
package jack_detect_pkg;
    localparam int          CLOCK_HZ         = 100_000_000;
    localparam int          MS_PER_S         = 1000;
    localparam int          MS_TICK_DEFAULT  = CLOCK_HZ / MS_PER_S;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          TIMEOUT_W        = 8;
    localparam int          SENSE_W          = 2;

    // register offsets
    localparam logic [7:0]  OFS_FLAGS        = 8'h01;
    localparam logic [7:0]  OFS_JACK_STATUS  = 8'h02;
    localparam logic [7:0]  OFS_FLAG_MASK    = 8'h03;
    localparam logic [7:0]  OFS_JACK_CONFIG  = 8'h3D;

    // field positions
    localparam int          BIT_DETECT_EN    = 7;
    localparam int          BIT_WEAK_PULLUP  = 6;
    localparam int          BIT_DEB_LO       = 0;
    localparam int          BIT_LOAD_SENSE   = 2;
    localparam int          BIT_TYPE_SENSE   = 1;
    localparam int          BIT_CHANGE_FLAG  = 2;
    localparam int          BIT_CHANGE_MASK  = 2;

    // index of each comparator within the sense vector
    localparam int          IDX_TYPE         = 0;
    localparam int          IDX_LOAD         = 1;

    // reset values
    localparam logic [7:0]  RST_CONFIG       = 8'h00;
    localparam logic        RST_MASK         = 1'b0;
    localparam logic [1:0]  RST_SENSE        = 2'h0;

    // debounce timeouts in milliseconds
    localparam logic [7:0]  DEB_MS_0         = 8'h19;
    localparam logic [7:0]  DEB_MS_1         = 8'h32;
    localparam logic [7:0]  DEB_MS_2         = 8'h64;
    localparam logic [7:0]  DEB_MS_3         = 8'hC8;

    function automatic logic [TIMEOUT_W-1:0] debounce_ms(input logic [1:0] sel);
        case (sel)
            2'h0:    debounce_ms = DEB_MS_0;
            2'h1:    debounce_ms = DEB_MS_1;
            2'h2:    debounce_ms = DEB_MS_2;
            default: debounce_ms = DEB_MS_3;
        endcase
    endfunction
endpackage

//--- core/debounce_if.sv
// carrier between the status logic and its debounce filter
// assumes both ends sit on the same clock
interface debounce_if;
    import jack_detect_pkg::*;
    logic [SENSE_W-1:0]   sample;
    logic                 enable;
    logic                 ms_tick;
    logic [1:0]           select;
    logic [SENSE_W-1:0]   stable;
    logic                 changed;

    modport owner  (output sample, output enable, output ms_tick, output select,
                    input stable, input changed);
    modport filter (input sample, input enable, input ms_tick, input select,
                    output stable, output changed);
endinterface

//--- core/jack_debounce.sv
// debounce filter for the two comparator outputs
// assumes samples are already synchronised and ms_tick is a one-cycle pulse
module jack_debounce
    import jack_detect_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           sys_rst,
    debounce_if.filter          dbi
);
    logic [SENSE_W-1:0]   stable;
    logic [SENSE_W-1:0]   next_stable;
    logic [SENSE_W-1:0]   last_sample;
    logic [SENSE_W-1:0]   next_last_sample;
    logic [TIMEOUT_W-1:0] ms_count;
    logic [TIMEOUT_W-1:0] next_ms_count;
    logic                 changed;
    logic                 next_changed;

    always_comb begin
        next_stable      = stable;
        next_last_sample = last_sample;
        next_ms_count    = ms_count;
        next_changed     = 1'b0;
        if (dbi.enable) begin
            next_last_sample = dbi.sample;
            if (dbi.sample != last_sample || dbi.sample == stable) begin
                next_ms_count = '0;
            end else if (dbi.ms_tick) begin
                if (ms_count >= debounce_ms(dbi.select)) begin
                    next_stable   = dbi.sample;
                    next_changed  = 1'b1;
                    next_ms_count = '0;
                end else begin
                    next_ms_count = ms_count + 1'b1;
                end
            end
        end else begin
            next_ms_count = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stable      <= RST_SENSE;
            last_sample <= RST_SENSE;
            ms_count    <= '0;
            changed     <= 1'b0;
        end else begin
            stable      <= next_stable;
            last_sample <= next_last_sample;
            ms_count    <= next_ms_count;
            changed     <= next_changed;
        end
    end

    assign dbi.stable  = stable;
    assign dbi.changed = changed;
endmodule

//--- core/jack_detect_status_logic.sv
// jack insertion and type detection: control, status and change flag
// assumes comparator outputs arrive asynchronously; mode inputs are on clock
// register port: reg_wr / reg_rd strobes one cycle, read data one cycle later
// Overview of operation
// - detect circuitry powered only while detect enable bit 7 is set; resets off
// - while detection is disabled, sense flags hold their last valid result
// - weak pullup select 0 strong, 1 weak; applies when bias off or shutdown
// - enabled, active and mic bias on: internal pullup off, pin high impedance
// - reference is mic bias output only when bias and active both set
// - load sense bit 2: 1 above 95 percent of reference, else 0
// - jack type sense bit 1: 0 below 10 percent of reference, else 1
// - no jack reports load sense 1 and type sense 1
// - headphone plug grounding pin reports load 0 and type 0
// - headset biasing pin between thresholds reports load 0, type 1
// - debounce select bits 1:0 give 25, 50, 100, 200 ms; reset 00
// - button detection valid with mic bias on, or strong pullup selected
// - button press drives type sense 1 to 0, raising change flag
// - sense flags update only after new state persists beyond timeout
// - any sense flag change sets change flag; unmasked asserts interrupt low
// - reading flag register clears change flag and interrupt
module jack_detect_status_logic
    import jack_detect_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_TICK_DEFAULT
)
(
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    input  wire logic [jack_detect_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [jack_detect_pkg::DATA_W-1:0] reg_wdata,
    output logic      [jack_detect_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                              load_cmp_in,
    input  wire logic                              type_cmp_in,
    input  wire logic                              mic_bias_enable,
    input  wire logic                              shutdown_n,
    output logic                                   detect_power_en,
    output logic                                   pullup_strong_en,
    output logic                                   pullup_weak_en,
    output logic                                   ref_from_mic_bias,
    output logic                                   button_detect_ok,
    output logic                                   irq_n_out,
    output logic                                   irq_n_oe
);
    localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);

    // refuse settings the logic cannot serve
    if (MS_TICK_CYCLES < 1) begin : g_tick_check
        $error("MS_TICK_CYCLES must be at least one");
    end
    if (SENSE_W != 2) begin : g_sense_check
        $error("the sense vector must hold exactly two comparators");
    end

    // carrier to the debounce filter
    debounce_if dbi ();

    // comparator synchronisers
    logic [SENSE_W-1:0] sense_meta;
    logic [SENSE_W-1:0] sense_sync;
    logic [SENSE_W-1:0] next_sense_meta;
    logic [SENSE_W-1:0] next_sense_sync;

    logic [TICK_W-1:0]  tick_count;
    logic [TICK_W-1:0]  next_tick_count;
    logic               ms_tick;
    logic               next_ms_tick;

    logic               detect_enable;
    logic               next_detect_enable;
    logic               weak_pullup_select;
    logic               next_weak_pullup_select;
    logic [1:0]         debounce_select;
    logic [1:0]         next_debounce_select;
    logic               change_flag_mask;
    logic               next_change_flag_mask;
    logic               config_change_flag;
    logic               next_config_change_flag;
    logic [DATA_W-1:0]  next_reg_rdata;
    logic               irq_active;
    logic               next_irq_active;
    logic               bias_mode;
    logic               config_write;
    logic               mask_write;

    // two flops: the comparators switch with no regard to clock
    always_comb begin
        next_sense_meta           = sense_meta;
        next_sense_meta[IDX_LOAD] = load_cmp_in;
        next_sense_meta[IDX_TYPE] = type_cmp_in;
        next_sense_sync           = sense_meta;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sense_meta <= RST_SENSE;
            sense_sync <= RST_SENSE;
        end else begin
            sense_meta <= next_sense_meta;
            sense_sync <= next_sense_sync;
        end
    end

    // millisecond tick, free-running
    // its phase lets a change wait up to one tick more
    always_comb begin
        next_ms_tick    = 1'b0;
        next_tick_count = tick_count + 1'b1;
        if (tick_count == TICK_W'(MS_TICK_CYCLES - 1)) begin
            next_tick_count = '0;
            next_ms_tick    = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_count <= '0;
            ms_tick    <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            ms_tick    <= next_ms_tick;
        end
    end

    // comparators deliver load above 95% and type at or above 10% directly
    assign dbi.sample  = sense_sync;
    assign dbi.enable  = detect_enable;
    assign dbi.ms_tick = ms_tick;
    assign dbi.select  = debounce_select;

    jack_debounce u_debounce (
        .clock   (clock),
        .sys_rst (sys_rst),
        .dbi     (dbi)
    );

    // decoded write strobes
    assign config_write = reg_wr && reg_addr == OFS_JACK_CONFIG;
    assign mask_write   = reg_wr && reg_addr == OFS_FLAG_MASK;

    // register file and change flag
    always_comb begin
        next_detect_enable      = detect_enable;
        next_weak_pullup_select = weak_pullup_select;
        next_debounce_select    = debounce_select;
        next_change_flag_mask   = change_flag_mask;
        next_config_change_flag = config_change_flag;
        next_reg_rdata          = reg_rdata;
        if (config_write) begin
            next_detect_enable      = reg_wdata[BIT_DETECT_EN];
            next_weak_pullup_select = reg_wdata[BIT_WEAK_PULLUP];
            next_debounce_select    = reg_wdata[BIT_DEB_LO +: 2];
        end
        if (mask_write) begin
            next_change_flag_mask = reg_wdata[BIT_CHANGE_MASK];
        end
        if (reg_rd) begin
            next_reg_rdata = '0;
            case (reg_addr)
                OFS_FLAGS: begin
                    next_reg_rdata[BIT_CHANGE_FLAG] = config_change_flag;
                    next_config_change_flag         = 1'b0;
                end
                OFS_JACK_STATUS: begin
                    next_reg_rdata[BIT_LOAD_SENSE] = dbi.stable[IDX_LOAD];
                    next_reg_rdata[BIT_TYPE_SENSE] = dbi.stable[IDX_TYPE];
                end
                OFS_FLAG_MASK: begin
                    next_reg_rdata[BIT_CHANGE_MASK] = change_flag_mask;
                end
                OFS_JACK_CONFIG: begin
                    next_reg_rdata[BIT_DETECT_EN]     = detect_enable;
                    next_reg_rdata[BIT_WEAK_PULLUP]   = weak_pullup_select;
                    next_reg_rdata[BIT_DEB_LO +: 2]   = debounce_select;
                end
                default: begin
                    next_reg_rdata = '0;
                end
            endcase
        end
        // a change in the read cycle still sets the flag
        if (dbi.changed) begin
            next_config_change_flag = 1'b1;
        end
        // registered so the pin never glitches
        next_irq_active = next_config_change_flag && next_change_flag_mask;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            detect_enable      <= RST_CONFIG[BIT_DETECT_EN];
            weak_pullup_select <= RST_CONFIG[BIT_WEAK_PULLUP];
            debounce_select    <= RST_CONFIG[BIT_DEB_LO +: 2];
            change_flag_mask   <= RST_MASK;
            config_change_flag <= 1'b0;
            reg_rdata          <= '0;
            irq_active         <= 1'b0;
        end else begin
            detect_enable      <= next_detect_enable;
            weak_pullup_select <= next_weak_pullup_select;
            debounce_select    <= next_debounce_select;
            change_flag_mask   <= next_change_flag_mask;
            config_change_flag <= next_config_change_flag;
            reg_rdata          <= next_reg_rdata;
            irq_active         <= next_irq_active;
        end
    end

    // analog steering
    // bias mode hands the pin to the external pullup, both internal ones off
    assign bias_mode         = mic_bias_enable && shutdown_n;
    assign detect_power_en   = detect_enable;
    assign pullup_strong_en  = detect_enable && !bias_mode && !weak_pullup_select;
    assign pullup_weak_en    = detect_enable && !bias_mode && weak_pullup_select;
    assign ref_from_mic_bias = bias_mode;
    assign button_detect_ok  = detect_enable && (mic_bias_enable || !weak_pullup_select);

    // open-drain interrupt pin, pulled low while asserted
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = irq_active;
endmodule

//--- verif/jack_detect_props.sv
// concurrent checks on the ports of the jack detect status logic
// assumes one clock domain and the register map of jack_detect_pkg
module jack_detect_props
    import jack_detect_pkg::*;
(
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              mic_bias_enable,
    input wire logic              shutdown_n,
    input wire logic              detect_power_en,
    input wire logic              pullup_strong_en,
    input wire logic              pullup_weak_en,
    input wire logic              ref_from_mic_bias,
    input wire logic              button_detect_ok,
    input wire logic              irq_n_out,
    input wire logic              irq_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flag_read_seen;
    logic mask_write_seen;
    logic status_read_seen;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock) begin
        flag_read_seen   <= !sys_rst && reg_rd && reg_addr == OFS_FLAGS;
        mask_write_seen  <= !sys_rst && reg_wr && reg_addr == OFS_FLAG_MASK;
        status_read_seen <= !sys_rst && reg_rd && reg_addr == OFS_JACK_STATUS;
    end
    AST_POWER_FOLLOWS: assert property (reg_wr && reg_addr == OFS_JACK_CONFIG |=>
        detect_power_en == $past(reg_wdata[BIT_DETECT_EN])) else $error("power enable wrong");
    AST_OFF_NO_PULL: assert property (!detect_power_en |->
        !pullup_strong_en && !pullup_weak_en) else $error("pullup on while detect off");
    AST_ONE_PULL: assert property (!(pullup_strong_en && pullup_weak_en))
        else $error("both pullups on");
    AST_BIAS_HIZ: assert property (detect_power_en && mic_bias_enable && shutdown_n |->
        !pullup_strong_en && !pullup_weak_en) else $error("pullup on in bias mode");
    AST_REF_SEL: assert property (ref_from_mic_bias == (mic_bias_enable && shutdown_n))
        else $error("reference select wrong");
    AST_STRONG_BUTTON: assert property (pullup_strong_en |-> button_detect_ok)
        else $error("button detect off with strong pullup");
    AST_WEAK_NO_BUTTON: assert property (pullup_weak_en && !mic_bias_enable |->
        !button_detect_ok) else $error("button detect on with weak pullup");
    AST_IRQ_LOW: assert property (irq_n_out == 1'b0) else $error("irq pin level");
    AST_IRQ_CLEAR: assert property ($fell(irq_n_oe) |->
        flag_read_seen || mask_write_seen) else $error("irq dropped without flag read");
    AST_IRQ_RISE: assert property ($rose(irq_n_oe) |->
        $past(detect_power_en) || mask_write_seen) else $error("irq raised while detect off");
    AST_RESERVED: assert property (status_read_seen |->
        reg_rdata[7:3] == 5'h00 && reg_rdata[0] == 1'b0) else $error("status reserved bits");
    cover property ($rose(irq_n_oe));
    cover property ($fell(irq_n_oe));
    cover property (pullup_weak_en);
endmodule

bind jack_detect_status_logic jack_detect_props jack_detect_props_i (.clock, .sys_rst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mic_bias_enable, .shutdown_n,
    .detect_power_en, .pullup_strong_en, .pullup_weak_en, .ref_from_mic_bias,
    .button_detect_ok, .irq_n_out, .irq_n_oe);

//--- verif/jack_model.sv
// comparator outputs seen for a plug on the sense pin
// plug: 0 open, 1 headphone, 2 headset, 3 headset with button held
// unpowered comparators show the opposite of a live reading, so a held status shows
module jack_model (
    input  wire logic       power,
    input  wire logic [1:0] plug,
    output logic            load_out,
    output logic            type_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic live_load;
    logic live_type;
    assign live_load = (plug == 2'h0);
    assign live_type = (plug[0] == 1'b0);
    assign load_out  = power ? live_load : !live_load;
    assign type_out  = power ? live_type : !live_type;
endmodule

//--- verif/tb_top.sv
// register level tests of the jack detect status logic
// assumes a 1 ms tick shortened to 10 cycles
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import jack_detect_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, prev;
    logic load_cmp_in, type_cmp_in, mic_bias_enable = 1'b0, shutdown_n = 1'b1;
    logic detect_power_en, pullup_strong_en, pullup_weak_en, ref_from_mic_bias;
    logic button_detect_ok, irq_n_out, irq_n_oe;
    logic [1:0] plug = 2'h0;
    int num_errors = 0, n_compared = 0;
    int ms_tab[4] = '{25, 50, 100, 200};
    logic [7:0] stat_tab[4] = '{8'h06, 8'h00, 8'h02, 8'h00};
    jack_detect_status_logic #(
        .MS_TICK_CYCLES    (10)
    ) jack_detect_status_logic_i (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .reg_addr          (reg_addr),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .load_cmp_in       (load_cmp_in),
        .type_cmp_in       (type_cmp_in),
        .mic_bias_enable   (mic_bias_enable),
        .shutdown_n        (shutdown_n),
        .detect_power_en   (detect_power_en),
        .pullup_strong_en  (pullup_strong_en),
        .pullup_weak_en    (pullup_weak_en),
        .ref_from_mic_bias (ref_from_mic_bias),
        .button_detect_ok  (button_detect_ok),
        .irq_n_out         (irq_n_out),
        .irq_n_oe          (irq_n_oe)
    );
    jack_model jack_model_i (.power(detect_power_en), .plug(plug),
        .load_out(load_cmp_in), .type_out(type_cmp_in));
    initial begin
        forever #5 clock = !clock;
    end
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1 chk($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    task automatic pins(input logic [3:0] exp);
        @(posedge clock);
        #1 chk("pins", {4'h0, pullup_strong_en, pullup_weak_en, ref_from_mic_bias,
            button_detect_ok}, {4'h0, exp});
        @(posedge clock);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(OFS_JACK_CONFIG, 8'h00);
        rd(OFS_JACK_STATUS, 8'h00);
        rd(OFS_FLAGS, 8'h00);
        rd(8'h55, 8'h00);
        prev = 8'h00;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FLAG_MASK, (i == 1) ? 8'h00 : 8'h04);
            wr(OFS_JACK_CONFIG, 8'hBC | 8'(i));
            rd(OFS_JACK_CONFIG, 8'h80 | 8'(i));
            plug <= 2'(i + 1);
            repeat (100) @(posedge clock);
            plug <= 2'(i);
            repeat (ms_tab[i] * 10 - 8) @(posedge clock);
            rd(OFS_JACK_STATUS, prev);
            repeat (30) @(posedge clock);
            rd(OFS_JACK_STATUS, stat_tab[i]);
            chk("irq", {6'h00, irq_n_out, irq_n_oe}, (i == 1) ? 8'h00 : 8'h01);
            rd(OFS_FLAGS, 8'h04);
            chk("irq clear", {7'h00, irq_n_oe}, 8'h00);
            rd(OFS_FLAGS, 8'h00);
            prev = stat_tab[i];
        end
        wr(OFS_JACK_CONFIG, 8'h00);
        plug <= 2'h2;
        #1 chk("power", {7'h00, detect_power_en}, 8'h00);
        repeat (400) @(posedge clock);
        rd(OFS_JACK_STATUS, 8'h00);
        rd(OFS_FLAGS, 8'h00);
        plug <= 2'h3;
        wr(OFS_JACK_CONFIG, 8'h80);
        mic_bias_enable <= 1'b1;
        pins(4'b0011);
        shutdown_n <= 1'b0;
        mic_bias_enable <= 1'b0;
        pins(4'b1001);
        shutdown_n <= 1'b1;
        wr(OFS_JACK_CONFIG, 8'hC0);
        pins(4'b0100);
        finish_test();
    end
endmodule
